// file: hdl/fcs_pkg.sv
package fcs_pkg;

  // ****************************************
  // Register addresses (32-bit, as decoded)
  // ****************************************
  localparam logic [31:0] ADDR_IFACE      = 32'h0000_0000;
  localparam logic [31:0] ADDR_DUMMY      = 32'h0000_0300;
  localparam logic [31:0] ADDR_PREAMBLE   = 32'h0000_0500;
  localparam logic [31:0] ADDR_ECC_STAT   = 32'h0000_0800;
  localparam logic [31:0] ADDR_FA_BYTE0   = 32'h0000_0C00;
  localparam logic [31:0] ADDR_FA_BYTE1   = 32'h0000_0D00;
  localparam logic [31:0] ADDR_FA_BYTE2   = 32'h0000_0E00;
  localparam logic [31:0] ADDR_FA_BYTE3   = 32'h0000_0F00;
  localparam logic [31:0] ADDR_OTP_BOOT   = 32'h4000_0000;
  localparam logic [31:0] ADDR_CMD_ERR    = 32'h8000_0000;
  localparam int          HALF_SEL_BIT    = 26;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FA_VALID_BIT     = 7;
  localparam int FA_STATE_LSB     = 4;
  localparam int PARITY_DIS_BIT   = 3;
  localparam int CMD_ERR_BIT      = 4;
  localparam int SEC_PROTSEL_BIT  = 7;
  localparam int SEC_EFAIL_BIT    = 6;
  localparam int SEC_PFAIL_BIT    = 5;
  localparam int SEC_ESUSP_BIT    = 3;
  localparam int SEC_PSUSP_BIT    = 2;
  localparam int SEC_LOCKDOWN_BIT = 1;
  localparam int SEC_FACTORY_BIT  = 0;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [1:0] OTP_BOOT_RST    = 2'h3;
  localparam logic       OTP_PARITY_RST  = 1'b1;
  localparam logic [2:0] DUMMY_RST       = 3'h0;
  localparam logic [3:0] FAIL_CNT_MAX    = 4'hF;
  localparam logic [4:0] DUMMY_BASE      = 5'h14;
  localparam logic [15:0] PRE_PAT_MAIN   = 16'h349A;
  localparam logic [15:0] PRE_PAT_LINE3  = 16'h3514;
  localparam logic [15:0] PRE_PAT_ALT    = 16'h5555;

  typedef enum logic [1:0] {
    FCS_IF_SERIAL,
    FCS_IF_SINGLE_OCTAL,
    FCS_IF_DOUBLE_OCTAL,
    FCS_IF_INHIBIT
  } fcs_iface_e;

endpackage

// file: hdl/fcs_ecc_half.sv
`timescale 1ns/1ps
module fcs_ecc_half
  import fcs_pkg::*;
#(
  parameter int AW = 26
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          fail_evt,
  input  wire logic [AW-1:0] fail_addr,
  input  wire logic [2:0]    fail_kind,
  output logic               fail_addr_valid,
  output logic [2:0]         ecc_fail_state,
  output logic [3:0]         fail_chunk_count,
  output logic [AW-1:0]      ecc_fail_chunk_addr
);

  logic          valid_q, valid_d;
  logic [2:0]    state_q, state_d;
  logic [3:0]    cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;

  always_comb begin
    valid_d = valid_q;
    state_d = state_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    if (fail_evt) begin
      state_d = state_q | fail_kind;
      // Every read of a bad chunk counts, saturating
      if (cnt_q != FAIL_CNT_MAX) begin
        cnt_d = cnt_q + 4'h1;
      end
      // Only the first failing chunk is kept
      if (!valid_q) begin
        valid_d = 1'b1;
        addr_d  = fail_addr;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      state_q <= 3'h0;
      cnt_q   <= 4'h0;
      addr_q  <= '0;
    end else begin
      valid_q <= valid_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
    end
  end

  assign fail_addr_valid     = valid_q;
  assign ecc_fail_state      = state_q;
  assign fail_chunk_count    = cnt_q;
  assign ecc_fail_chunk_addr = addr_q;

  chk_count_saturates: assert property (@(posedge mclk) disable iff (sys_rst)
    cnt_q == FAIL_CNT_MAX |=> cnt_q == FAIL_CNT_MAX)
    else $error("fail counter left saturation");
  chk_count_steps: assert property (@(posedge mclk) disable iff (sys_rst)
    fail_evt && cnt_q != FAIL_CNT_MAX |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("fail counter did not step");
  chk_addr_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    valid_q |=> addr_q == $past(addr_q) && valid_q)
    else $error("first fail address overwritten");
  chk_first_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    !valid_q && fail_evt |=> valid_q && addr_q == $past(fail_addr))
    else $error("first fail address not captured");

endmodule

// file: hdl/fcs_regs.sv
`timescale 1ns/1ps
// Function
// - Fail chunk address split over four bytes, bits 7:4 up to 25:24.
// - Only the first failing chunk address of each half is captured and kept.
// - Four-bit fail chunk counter saturates at 15.
// - Each read of a failing chunk increments the counter again.
// - Address bit 26 selects lower or upper half ECC status.
// - Parity checking enabled when OTP bit 3 is zero; default one.
// - OTP boot bits: 00 inhibit, 01 double, 10 single, 11 serial.
// - Volatile interface bits load inverted OTP boot bits at reset.
// - Command/parity error flag at bit 4 set on check failure.
// - Dummy code 000 gives 20 cycles, minus two per step.
// - Preamble select picks fixed patterns; line 3 differs when zero.
// - Erase fail flag set on failed or protected erase, cleared on success.
// - Program fail flag set on failed or protected program.
// - Fail flags only report; they never halt operations.
// - Erase suspended flag set on suspend, cleared on resume.
// - Program suspended flag set on suspend, cleared on resume.
// - Read-only factory lock bit reports OTP factory lock.
// - Security write sets customer lock-down; then protection select is frozen and otp_area_locked is set, but OTP boot bits stay writable.
// - Main array access blocked while in secured OTP mode.
// - Volatile bits at address zero select interface mode.
// - Valid flag at bit 7 shows a fail address was captured.
// - Reads rejected during internal write, except the error flag.
module fcs_regs
  import fcs_pkg::*;
#(
  parameter int AW = 26
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [31:0]   reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          write_in_progress,
  input  wire logic          ecc_fail_evt,
  input  wire logic [26:0]   ecc_fail_addr,
  input  wire logic [2:0]    ecc_fail_kind,
  input  wire logic          command_byte_check_fail,
  input  wire logic          parity_fail,
  input  wire logic          erase_done,
  input  wire logic          erase_bad,
  input  wire logic          program_done,
  input  wire logic          program_bad,
  input  wire logic          erase_suspend,
  input  wire logic          erase_resume,
  input  wire logic          program_suspend,
  input  wire logic          program_resume,
  input  wire logic          security_write_cmd,
  input  wire logic [7:0]    security_wdata,
  input  wire logic          otp_mode,
  input  wire logic          array_req,
  input  wire logic          factory_locked,
  output logic [7:0]         reg_rdata,
  output logic               reg_rd_ack,
  output logic               reg_rd_reject,
  output logic [7:0]         security_status,
  output logic               double_octal_sel,
  output logic               single_octal_sel,
  output logic               parity_check_en,
  output logic [4:0]         dummy_cycles,
  output logic [15:0]        preamble_main,
  output logic [15:0]        preamble_line3,
  output logic               otp_area_locked,
  output logic               array_grant
);

  // ****************************************
  // ECC fail tracking, one per half
  // ****************************************
  logic          lo_evt, hi_evt;
  logic          lo_vld, hi_vld;
  logic [2:0]    lo_st, hi_st;
  logic [3:0]    lo_cnt, hi_cnt;
  logic [AW-1:0] lo_fa, hi_fa;

  // Bit 26 routes each event to its half
  assign lo_evt = ecc_fail_evt && !ecc_fail_addr[HALF_SEL_BIT];
  assign hi_evt = ecc_fail_evt && ecc_fail_addr[HALF_SEL_BIT];

  fcs_ecc_half #(.AW(AW)) u_lo (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .fail_evt            (lo_evt),
    .fail_addr           (ecc_fail_addr[AW-1:0]),
    .fail_kind           (ecc_fail_kind),
    .fail_addr_valid     (lo_vld),
    .ecc_fail_state      (lo_st),
    .fail_chunk_count    (lo_cnt),
    .ecc_fail_chunk_addr (lo_fa)
  );

  fcs_ecc_half #(.AW(AW)) u_hi (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .fail_evt            (hi_evt),
    .fail_addr           (ecc_fail_addr[AW-1:0]),
    .fail_kind           (ecc_fail_kind),
    .fail_addr_valid     (hi_vld),
    .ecc_fail_state      (hi_st),
    .fail_chunk_count    (hi_cnt),
    .ecc_fail_chunk_addr (hi_fa)
  );

  // ****************************************
  // Configuration and status state
  // ****************************************
  // OTP cells survive sys_rst; power-up shows the blank value
  logic [1:0]  otp_boot_q = OTP_BOOT_RST;
  logic [1:0]  otp_boot_d;
  logic        otp_par_q  = OTP_PARITY_RST;
  logic        otp_par_d;
  logic        otp_prog_q = 1'b0;
  logic        otp_prog_d;
  logic [1:0]  iface_q, iface_d;
  logic        boot_load_q, boot_load_d;
  logic [2:0]  dummy_q, dummy_d;
  logic        pre_sel_q, pre_sel_d;
  logic        cmd_err_q, cmd_err_d;
  logic        efail_q, efail_d;
  logic        pfail_q, pfail_d;
  logic        esusp_q, esusp_d;
  logic        psusp_q, psusp_d;
  logic        lockdown_q, lockdown_d;
  logic        protsel_q, protsel_d;
  logic        wr_ok;
  logic        sel_hi;

  assign wr_ok  = reg_wr && !write_in_progress;
  assign sel_hi = reg_addr[HALF_SEL_BIT];

  always_comb begin
    otp_boot_d  = otp_boot_q;
    otp_par_d   = otp_par_q;
    otp_prog_d  = otp_prog_q;
    iface_d     = iface_q;
    boot_load_d = 1'b0;
    dummy_d     = dummy_q;
    pre_sel_d   = pre_sel_q;
    protsel_d   = protsel_q;
    // Volatile mode follows the inverted OTP boot bits after reset
    if (boot_load_q) begin
      iface_d = ~otp_boot_q;
    end
    if (wr_ok) begin
      unique case (reg_addr)
        ADDR_IFACE:    iface_d   = reg_wdata[1:0];
        ADDR_DUMMY:    dummy_d   = reg_wdata[2:0];
        ADDR_PREAMBLE: pre_sel_d = reg_wdata[0];
        ADDR_OTP_BOOT: begin
          // OTP bits can only be programmed from 1 to 0
          if (!otp_prog_q) begin
            otp_boot_d = otp_boot_q & reg_wdata[1:0];
            otp_par_d  = otp_par_q & reg_wdata[PARITY_DIS_BIT];
            otp_prog_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (security_write_cmd && !lockdown_q) begin
      protsel_d = protsel_q | security_wdata[SEC_PROTSEL_BIT];
    end
  end

  // No reset here, or a reset would undo the boot mode it must load
  always_ff @(posedge mclk) begin
    otp_boot_q <= otp_boot_d;
    otp_par_q  <= otp_par_d;
    otp_prog_q <= otp_prog_d;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      iface_q     <= ~OTP_BOOT_RST;
      boot_load_q <= 1'b1;
      dummy_q     <= DUMMY_RST;
      pre_sel_q   <= 1'b0;
      protsel_q   <= 1'b0;
    end else begin
      iface_q     <= iface_d;
      boot_load_q <= boot_load_d;
      dummy_q     <= dummy_d;
      pre_sel_q   <= pre_sel_d;
      protsel_q   <= protsel_d;
    end
  end

  // ****************************************
  // Event flags: set wins over clear
  // ****************************************
  always_comb begin
    cmd_err_d  = command_byte_check_fail || parity_fail;
    efail_d    = efail_q;
    pfail_d    = pfail_q;
    esusp_d    = esusp_q;
    psusp_d    = psusp_q;
    lockdown_d = lockdown_q;
    // Flags only report; nothing here stops the flash core
    if (erase_done || program_done) begin
      efail_d = erase_done && erase_bad;
      pfail_d = program_done && program_bad;
    end
    if (erase_resume) esusp_d = 1'b0;
    if (erase_suspend) esusp_d = 1'b1;
    if (program_resume) psusp_d = 1'b0;
    if (program_suspend) psusp_d = 1'b1;
    // Lock-down is one-way
    if (security_write_cmd && security_wdata[SEC_LOCKDOWN_BIT]) begin
      lockdown_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_err_q  <= 1'b0;
      efail_q    <= 1'b0;
      pfail_q    <= 1'b0;
      esusp_q    <= 1'b0;
      psusp_q    <= 1'b0;
      lockdown_q <= 1'b0;
    end else begin
      cmd_err_q  <= cmd_err_d;
      efail_q    <= efail_d;
      pfail_q    <= pfail_d;
      esusp_q    <= esusp_d;
      psusp_q    <= psusp_d;
      lockdown_q <= lockdown_d;
    end
  end

  // ****************************************
  // Read path and derived outputs
  // ****************************************
  logic [7:0]  rdata_d;
  logic        ack_d, rej_d;
  logic [7:0]  sec_d;
  logic        dos_d, sos_d, par_en_d, grant_d;
  logic [4:0]  dcyc_d;
  logic [15:0] pm_d, p3_d;
  logic [AW-1:0] fa;

  assign fa = sel_hi ? hi_fa : lo_fa;

  always_comb begin
    rdata_d = 8'h00;
    rej_d   = 1'b0;
    ack_d   = 1'b0;
    if (reg_rd) begin
      // Busy core: only the error flag may be read
      if (write_in_progress && reg_addr != ADDR_CMD_ERR) begin
        rej_d = 1'b1;
      end else begin
        ack_d = 1'b1;
        unique case ({5'h00, reg_addr[HALF_SEL_BIT], 26'h0} ^ reg_addr)
          ADDR_IFACE:    rdata_d = {6'h00, iface_q};
          ADDR_DUMMY:    rdata_d = {5'h00, dummy_q};
          ADDR_PREAMBLE: rdata_d = {7'h00, pre_sel_q};
          ADDR_ECC_STAT: rdata_d = sel_hi ? {hi_vld, hi_st, hi_cnt}
                                          : {lo_vld, lo_st, lo_cnt};
          ADDR_FA_BYTE0: rdata_d = {fa[7:4], 4'h0};
          ADDR_FA_BYTE1: rdata_d = fa[15:8];
          ADDR_FA_BYTE2: rdata_d = fa[23:16];
          ADDR_FA_BYTE3: rdata_d = {6'h00, fa[25:24]};
          ADDR_OTP_BOOT: rdata_d = {4'h0, otp_par_q, 1'b0, otp_boot_q};
          ADDR_CMD_ERR:  rdata_d = {3'h0, cmd_err_q, 4'h0};
          default:       rdata_d = 8'h00;
        endcase
      end
    end
    sec_d = 8'h00;
    sec_d[SEC_PROTSEL_BIT]  = protsel_q;
    sec_d[SEC_EFAIL_BIT]    = efail_q;
    sec_d[SEC_PFAIL_BIT]    = pfail_q;
    sec_d[SEC_ESUSP_BIT]    = esusp_q;
    sec_d[SEC_PSUSP_BIT]    = psusp_q;
    sec_d[SEC_LOCKDOWN_BIT] = lockdown_q;
    sec_d[SEC_FACTORY_BIT]  = factory_locked;
    dos_d    = iface_q == 2'h2;
    sos_d    = iface_q == 2'h1;
    par_en_d = !otp_par_q;
    dcyc_d   = DUMMY_BASE - {1'b0, dummy_q, 1'b0};
    pm_d     = pre_sel_q ? PRE_PAT_ALT : PRE_PAT_MAIN;
    p3_d     = pre_sel_q ? PRE_PAT_ALT : PRE_PAT_LINE3;
    grant_d  = array_req && !otp_mode;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata        <= 8'h00;
      reg_rd_ack       <= 1'b0;
      reg_rd_reject    <= 1'b0;
      security_status  <= 8'h00;
      double_octal_sel <= 1'b0;
      single_octal_sel <= 1'b0;
      parity_check_en  <= 1'b0;
      dummy_cycles     <= DUMMY_BASE;
      preamble_main    <= PRE_PAT_MAIN;
      preamble_line3   <= PRE_PAT_LINE3;
      otp_area_locked  <= 1'b0;
      array_grant      <= 1'b0;
    end else begin
      reg_rdata        <= rdata_d;
      reg_rd_ack       <= ack_d;
      reg_rd_reject    <= rej_d;
      security_status  <= sec_d;
      double_octal_sel <= dos_d;
      single_octal_sel <= sos_d;
      parity_check_en  <= par_en_d;
      dummy_cycles     <= dcyc_d;
      preamble_main    <= pm_d;
      preamble_line3   <= p3_d;
      otp_area_locked  <= lockdown_q || factory_locked;
      array_grant      <= grant_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_secwr_lock;
    security_write_cmd && security_wdata[SEC_LOCKDOWN_BIT];
  endsequence

  chk_lock_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    lockdown_q |=> lockdown_q)
    else $error("lock-down bit cleared");
  chk_lock_set: assert property (@(posedge mclk) disable iff (sys_rst)
    s_secwr_lock |=> ##1 security_status[SEC_LOCKDOWN_BIT])
    else $error("lock-down not reported");
  chk_cmd_err: assert property (@(posedge mclk) disable iff (sys_rst)
    command_byte_check_fail || parity_fail |=> cmd_err_q)
    else $error("command error flag not set");
  chk_busy_reject: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd && write_in_progress && reg_addr != ADDR_CMD_ERR
      |=> reg_rd_reject && !reg_rd_ack)
    else $error("read not rejected while busy");
  chk_dummy_map: assert property (@(posedge mclk) disable iff (sys_rst)
    dummy_q == 3'h7 |=> dummy_cycles == 5'h06)
    else $error("dummy count wrong for code 7");
  chk_array_block: assert property (@(posedge mclk) disable iff (sys_rst)
    otp_mode |=> !array_grant)
    else $error("array granted in OTP mode");
  chk_esusp_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    erase_suspend |=> esusp_q ##1 security_status[SEC_ESUSP_BIT])
    else $error("erase suspend not flagged");
  chk_pfail_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    program_done && program_bad |=> pfail_q)
    else $error("program fail not flagged");
  chk_parity_en: assert property (@(posedge mclk) disable iff (sys_rst)
    !otp_par_q |=> parity_check_en)
    else $error("parity check not enabled");

endmodule

// file: sim/fcs_host.sv
`timescale 1ns/1ps
// ****************************************
// Host controller register access model
// ****************************************
module fcs_host (
  input  wire logic        mclk,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_rd_ack,
  input  wire logic        reg_rd_reject,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [31:0]      reg_addr,
  output logic [7:0]       reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 32'h0;
    reg_wdata = 8'h0;
  end

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr    = 1'b0;
    // Released lines flip so stale values never pass
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [31:0] a, output logic [7:0] d,
                    output logic rej, output logic ok);
    ok  = 1'b0;
    rej = 1'b0;
    d   = 8'h0;
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    // Answer stands one cycle only, so look before waiting again
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rd_ack === 1'b1 || reg_rd_reject === 1'b1) begin
        ok  = 1'b1;
        rej = reg_rd_reject;
        d   = reg_rdata;
      end else begin
        @(negedge mclk);
      end
    end
  endtask
endmodule

// file: sim/fcs_regs_tb.sv
`timescale 1ns/1ps
module fcs_regs_tb
  import fcs_pkg::*;
;
  logic        mclk = 1'b0, sys_rst = 1'b1, write_in_progress = 1'b0;
  logic        reg_wr, reg_rd, reg_rd_ack, reg_rd_reject;
  logic [31:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, security_status;
  logic [7:0]  security_wdata = 8'h0;
  logic        ecc_fail_evt = 1'b0, command_byte_check_fail = 1'b0;
  logic [26:0] ecc_fail_addr = 27'h0;
  logic [2:0]  ecc_fail_kind = 3'h0;
  logic        parity_fail = 1'b0, erase_bad = 1'b0, program_bad = 1'b0;
  logic        otp_mode = 1'b0, array_req = 1'b1, factory_locked = 1'b0;
  logic        double_octal_sel, single_octal_sel, parity_check_en;
  logic        otp_area_locked, array_grant;
  logic [4:0]  dummy_cycles;
  logic [15:0] preamble_main, preamble_line3;
  logic [6:0]  evk = 7'h0;
  wire logic   erase_done, program_done, erase_suspend, erase_resume;
  wire logic   program_suspend, program_resume, security_write_cmd;
  int          bad_count = 0, checks_done = 0;
  logic [31:0] seed = 32'h1F81DDCD;
  logic [26:0] fa, fb;
  logic [7:0]  d;
  logic        rj, ok;
  logic [6:0]  sk [10] = '{7'h40, 7'h40, 7'h20, 7'h20, 7'h10,
                           7'h04, 7'h08, 7'h02, 7'h01, 7'h01};
  logic [1:0]  sb [10] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0,
                           2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [7:0]  se [10] = '{8'h40, 8'h00, 8'h20, 8'h00, 8'h08,
                           8'h0C, 8'h04, 8'h00, 8'h02, 8'h02};

  assign {erase_done, program_done, erase_suspend, erase_resume,
          program_suspend, program_resume, security_write_cmd} = evk;

  // 50 MHz stays under the slowest dummy code limit
  always #10 mclk = ~mclk;

  fcs_regs dut_u (
    .mclk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .write_in_progress, .ecc_fail_evt, .ecc_fail_addr, .ecc_fail_kind,
    .command_byte_check_fail, .parity_fail, .erase_done, .erase_bad,
    .program_done, .program_bad, .erase_suspend, .erase_resume,
    .program_suspend, .program_resume, .security_write_cmd,
    .security_wdata, .otp_mode, .array_req, .factory_locked, .reg_rdata,
    .reg_rd_ack, .reg_rd_reject, .security_status, .double_octal_sel,
    .single_octal_sel, .parity_check_en, .dummy_cycles, .preamble_main,
    .preamble_line3, .otp_area_locked, .array_grant
  );

  fcs_host host_u (
    .mclk, .reg_rdata, .reg_rd_ack, .reg_rd_reject,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [4:0] dc_exp(input logic [2:0] c);
    return 5'h14 - {1'b0, c, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [7:0] e,
                     input logic r);
    host_u.rd(a, d, rj, ok);
    if (!ok) begin
      bad_count++;
      give_verdict();
    end
    chk(32'({rj, d}), 32'({r, e}));
  endtask

  task automatic rst_seq();
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic fail_ev(input logic [26:0] a, input logic [2:0] k);
    @(negedge mclk);
    ecc_fail_evt  = 1'b1;
    ecc_fail_addr = a;
    ecc_fail_kind = k;
    @(negedge mclk);
    ecc_fail_evt  = 1'b0;
    ecc_fail_addr = ~a;
  endtask

  task automatic fa_chk(input logic [31:0] h, input logic [26:0] a);
    host_u.rd(h | ADDR_ECC_STAT, d, rj, ok);
    chk(32'(d[7]), 32'h1);
    // Address bytes only trusted once the valid flag is seen
    if (d[7] === 1'b1) begin
      rdc(h | ADDR_FA_BYTE0, {a[7:4], 4'h0}, 1'b0);
      rdc(h | ADDR_FA_BYTE1, a[15:8], 1'b0);
      rdc(h | ADDR_FA_BYTE2, a[23:16], 1'b0);
      rdc(h | ADDR_FA_BYTE3, {6'h0, a[25:24]}, 1'b0);
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_seq();
    chk(32'(dummy_cycles), 32'h14);
    chk({preamble_main, preamble_line3}, 32'h349A3514);
    chk(32'({double_octal_sel, single_octal_sel}), 32'h0);
    chk(32'(parity_check_en), 32'h0);
    rdc(ADDR_ECC_STAT, 8'h00, 1'b0);
    rdc(ADDR_CMD_ERR, 8'h00, 1'b0);
    rdc(ADDR_OTP_BOOT, 8'h0B, 1'b0);
    rdc(32'h0000_0100, 8'h00, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      host_u.wr(ADDR_IFACE, {seed[7:2], 2'(i)});
      @(negedge mclk);
      chk(32'({double_octal_sel, single_octal_sel}), 32'(i));
      rdc(ADDR_IFACE, {6'h0, 2'(i)}, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      host_u.wr(ADDR_DUMMY, {seed[7:3], 3'(i)});
      @(negedge mclk);
      chk(32'(dummy_cycles), 32'(dc_exp(3'(i))));
      rdc(ADDR_DUMMY, {5'h0, 3'(i)}, 1'b0);
    end
    for (int i = 1; i >= 0; i--) begin
      host_u.wr(ADDR_PREAMBLE, 8'(i));
      @(negedge mclk);
      chk({preamble_main, preamble_line3},
          (i == 1) ? 32'h55555555 : 32'h349A3514);
    end
    $display("test config done");
    write_in_progress       = 1'b1;
    command_byte_check_fail = 1'b1;
    host_u.wr(ADDR_DUMMY, 8'h02);
    @(negedge mclk);
    chk(32'(dummy_cycles), 32'h06);
    rdc(ADDR_DUMMY, 8'h00, 1'b1);
    rdc(ADDR_CMD_ERR, 8'h10, 1'b0);
    command_byte_check_fail = 1'b0;
    parity_fail             = 1'b1;
    write_in_progress       = 1'b0;
    repeat (2) @(negedge mclk);
    rdc(ADDR_CMD_ERR, 8'h10, 1'b0);
    parity_fail = 1'b0;
    repeat (2) @(negedge mclk);
    rdc(ADDR_CMD_ERR, 8'h00, 1'b0);
    $display("test busy done");
    seed = lfsr(seed);
    fa   = {1'b0, seed[25:0]};
    fail_ev(fa, 3'h1);
    seed = lfsr(seed);
    fail_ev({1'b0, seed[25:0]}, 3'h2);
    rdc(ADDR_ECC_STAT, 8'hB2, 1'b0);
    fa_chk(32'h0, fa);
    rdc(32'h0400_0800, 8'h00, 1'b0);
    for (int i = 0; i < 14; i++) begin
      fail_ev({1'b0, seed[25:0]}, 3'h1);
    end
    rdc(ADDR_ECC_STAT, 8'hBF, 1'b0);
    seed = lfsr(seed);
    fb   = {1'b1, seed[25:0]};
    fail_ev(fb, 3'h4);
    rdc(32'h0400_0800, 8'hC1, 1'b0);
    fa_chk(32'h0400_0000, fb);
    rdc(ADDR_ECC_STAT, 8'hBF, 1'b0);
    $display("test ecc done");
    for (int i = 0; i < 10; i++) begin
      {erase_bad, program_bad} = sb[i];
      security_wdata = (i == 8) ? 8'h02 : 8'h00;
      @(negedge mclk);
      evk = sk[i];
      @(negedge mclk);
      evk = 7'h0;
      @(negedge mclk);
      chk(32'(security_status), 32'(se[i]));
      chk(32'(array_grant), 32'h1);
      chk(32'(otp_area_locked), 32'(i >= 8));
    end
    factory_locked = 1'b1;
    repeat (2) @(negedge mclk);
    chk(32'(security_status), 32'h03);
    otp_mode = 1'b1;
    repeat (2) @(negedge mclk);
    chk(32'(array_grant), 32'h0);
    otp_mode = 1'b0;
    $display("test security done");
    host_u.wr(ADDR_OTP_BOOT, 8'hF5);
    @(negedge mclk);
    chk(32'(parity_check_en), 32'h1);
    rdc(ADDR_OTP_BOOT, 8'h01, 1'b0);
    rst_seq();
    chk(32'({double_octal_sel, single_octal_sel}), 32'h2);
    rdc(ADDR_IFACE, 8'h02, 1'b0);
    rdc(ADDR_ECC_STAT, 8'h00, 1'b0);
    $display("test boot done");
    give_verdict();
  end
endmodule
